//--- core/p3pc_params.svh
`ifndef P3PC_PARAMS_SVH
`define P3PC_PARAMS_SVH

// ****************************************
// register indices, byte address is four times the index
// ****************************************
`define P3PC_LATCH_IDX 32'hfffff406
`define P3PC_DIR_IDX 32'hfffff426
`define P3PC_FEN_IDX 32'hfffff446
`define P3PC_ALT_IDX 32'hfffff466
`define P3PC_EXT_IDX 32'hfffff706

// ****************************************
// implemented bits and reset values
// ****************************************
`define P3PC_PIN_MASK 16'h033f
`define P3PC_EXT_MASK 16'h0004
`define P3PC_LATCH_RST 16'h0000
`define P3PC_DIR_RST 16'hffff
`define P3PC_FEN_RST 16'h0000
`define P3PC_ALT_RST 16'h0000
`define P3PC_EXT_RST 16'h0000
`define P3PC_EXT_PIN2_BIT 2

`endif

//--- core/p3pc_pkg.sv
package p3pc_pkg;

  // order matches {extension bit, select bit} of pin 2
  typedef enum logic [1:0] {
    p3pc_pin2_baud,
    p3pc_pin2_sclk,
    p3pc_pin2_cap,
    p3pc_pin2_cmp
  } p3pc_pin2_fn_e;

  typedef enum logic [1:0] {
    p3pc_htrans_idle,
    p3pc_htrans_busy,
    p3pc_htrans_nonseq,
    p3pc_htrans_seq
  } p3pc_htrans_e;

  typedef logic [9:0] p3pc_pins_t;

endpackage : p3pc_pkg

//--- core/p3pc_reg16.sv
`timescale 1ns/1ns
`default_nettype none
module p3pc_reg16 import p3pc_pkg::*; #(
  parameter logic [15:0] p_reset = 16'h0000,
  parameter logic [15:0] p_mask = 16'hffff
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [15:0] wdata,
  output logic [15:0] q,
  output logic [15:0] next_q
);

  // missing bits are pinned to their reset level
  always_comb begin
    next_q = q;
    if (wr_lo) begin
      next_q[7:0] = wdata[7:0];
    end
    if (wr_hi) begin
      next_q[15:8] = wdata[15:8];
    end
    next_q = (next_q & p_mask) | (p_reset & ~p_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= p_reset;
    end else begin
      q <= next_q;
    end
  end

endmodule : p3pc_reg16
`default_nettype wire

//--- core/p3pc_pin_cell.sv
`timescale 1ns/1ns
`default_nettype none
module p3pc_pin_cell import p3pc_pkg::*; (
  input wire logic fen,
  input wire logic dir,
  input wire logic latch,
  input wire logic alt_out,
  input wire logic alt_oe,
  output logic next_out,
  output logic next_oe
);

  // in alternate mode alt_oe, not dir, sets the direction
  always_comb begin
    if (fen) begin
      next_out = alt_out;
      next_oe = alt_oe;
    end else begin
      next_out = latch;
      next_oe = ~dir;
    end
  end

endmodule : p3pc_pin_cell
`default_nettype wire

//--- core/p3pc_top.sv
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "p3pc_params.svh"

// How it works
// - latch resets to zero; in output mode latch bit drives pin level
// - direction bit 0 makes output, 1 input; resets all ones
// - function enable bit 0 plain port, 1 alternate function; resets zero
// - all four port registers take 16-bit and byte-wide accesses
// - bits 15..8 also appear as bits 7..0 at next index
// - pin 2 alternate: baud clock, serial4 clock, capture0 or compare0
// - pin 1 feeds uart0 rx, serial4 in or irq7; pin 0 transmits
// - pins 9 and 8 select uart2 or i2c lines
// - pins 3,4,5 serve timer0 ch1, timer1 ch0 and ch1
// - missing pins: direction fixed 1, other bits fixed 0
// - extension register resets zero, only bit 2 exists
// - pin 2 function encoded by extension bit and select bit
// - pin 9 select 0 uart2 rx, 1 i2c clock; pin 8 likewise
// - pins 3..5 select 0 capture input, 1 compare output
module p3pc_top import p3pc_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [9:0] pin_in,
  output logic [9:0] pin_out,
  output logic [9:0] pin_oe,
  input wire logic uart0_transmit,
  input wire logic serial4_data_out,
  input wire logic serial4_clock_out,
  input wire logic serial4_clock_oe,
  input wire logic timer0_compare_out0,
  input wire logic timer0_compare_out1,
  input wire logic timer1_compare_out0,
  input wire logic timer1_compare_out1,
  input wire logic uart2_transmit,
  input wire logic i2c0_data_line_out,
  input wire logic i2c0_data_line_oe,
  input wire logic i2c0_clock_line_out,
  input wire logic i2c0_clock_line_oe,
  output logic uart0_receive,
  output logic external_irq7_in,
  output logic serial4_data_in,
  output logic uart0_baud_clock_in,
  output logic serial4_clock_in,
  output logic timer0_capture_in0,
  output logic timer0_capture_in1,
  output logic timer1_capture_in0,
  output logic timer1_capture_in1,
  output logic uart2_receive,
  output logic i2c0_data_line_in,
  output logic i2c0_clock_line_in
);

  // ****************************************
  // register identities
  // ****************************************
  localparam logic [3:0][31:0] reg_idx = {
    `P3PC_ALT_IDX, `P3PC_FEN_IDX, `P3PC_DIR_IDX, `P3PC_LATCH_IDX
  };
  localparam logic [3:0][15:0] reg_rst = {
    `P3PC_ALT_RST, `P3PC_FEN_RST, `P3PC_DIR_RST, `P3PC_LATCH_RST
  };
  localparam logic [31:0] ext_addr = `P3PC_EXT_IDX << 2;
  localparam logic [15:0] pin_mask = `P3PC_PIN_MASK;

  // ****************************************
  // bus address phase
  // ****************************************
  logic addr_valid;
  logic [3:0] next_be;
  logic dp_wr;
  logic [31:0] dp_addr;
  logic [3:0] dp_be;

  assign addr_valid = hsel & hready & htrans[1];

  always_comb begin
    next_be = 4'h0;
    unique case (hsize)
      3'h0: next_be = 4'h1 << haddr[1:0];
      3'h1: next_be = haddr[1] ? 4'hc : 4'h3;
      default: next_be = 4'hf;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_addr <= 32'h0;
      dp_be <= 4'h0;
    end else if (hready) begin
      dp_wr <= addr_valid & hwrite;
      dp_addr <= {haddr[31:2], 2'h0};
      dp_be <= next_be;
    end
  end

  // zero wait states, never an error
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // port registers
  // ****************************************
  logic [15:0] reg_q [4];
  logic [15:0] reg_next [4];
  logic [3:0] rd_hit_lo;
  logic [3:0] rd_hit_hi;

  for (genvar g = 0; g < 4; g++) begin : g_reg
    localparam logic [31:0] lo_addr = reg_idx[g] << 2;
    localparam logic [31:0] hi_addr = (reg_idx[g] + 32'h1) << 2;
    logic hit_lo;
    logic hit_hi;
    logic wr_lo;
    logic wr_hi;
    logic [15:0] wdata;

    assign hit_lo = dp_wr & (dp_addr == lo_addr);
    assign hit_hi = dp_wr & (dp_addr == hi_addr);
    assign wr_lo = hit_lo & dp_be[0];
    assign wr_hi = (hit_lo & dp_be[1]) | (hit_hi & dp_be[0]);
    assign wdata = hit_hi ? {hwdata[7:0], 8'h00} : hwdata[15:0];
    assign rd_hit_lo[g] = haddr[31:2] == lo_addr[31:2];
    assign rd_hit_hi[g] = haddr[31:2] == hi_addr[31:2];

    p3pc_reg16 #(
      .p_reset(reg_rst[g]),
      .p_mask(pin_mask)
    ) u_reg (
      .hclk(hclk),
      .hresetn(hresetn),
      .wr_lo(wr_lo),
      .wr_hi(wr_hi),
      .wdata(wdata),
      .q(reg_q[g]),
      .next_q(reg_next[g])
    );
  end

  logic ext_wr;
  logic [15:0] ext_q;
  logic [15:0] ext_next;

  assign ext_wr = dp_wr & (dp_addr == ext_addr) & dp_be[0];

  p3pc_reg16 #(
    .p_reset(`P3PC_EXT_RST),
    .p_mask(`P3PC_EXT_MASK)
  ) u_ext (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_lo(ext_wr),
    .wr_hi(1'b0),
    .wdata({8'h00, hwdata[7:0]}),
    .q(ext_q),
    .next_q(ext_next)
  );

  // ****************************************
  // read path
  // ****************************************
  // read mux looks at next values so a read right after a write sees it
  logic [15:0] latch_view;
  logic [15:0] view [4];
  logic [31:0] next_rdata;

  assign latch_view = (reg_next[0] & ~reg_next[1])
                    | ({6'h00, pin_in} & reg_next[1] & pin_mask);

  always_comb begin
    view[0] = latch_view;
    view[1] = reg_next[1];
    view[2] = reg_next[2];
    view[3] = reg_next[3];
  end

  always_comb begin
    next_rdata = 32'h0;
    for (int i = 0; i < 4; i++) begin
      if (rd_hit_lo[i]) begin
        next_rdata = {16'h0000, view[i]};
      end
      if (rd_hit_hi[i]) begin
        next_rdata = {24'h000000, view[i][15:8]};
      end
    end
    if (haddr[31:2] == ext_addr[31:2]) begin
      next_rdata = {24'h000000, ext_next[7:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_valid & ~hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ****************************************
  // alternate function outputs
  // ****************************************
  logic [9:0] latch_q;
  logic [9:0] dir_q;
  logic [9:0] fen_q;
  logic [9:0] alt_q;
  p3pc_pin2_fn_e pin2_fn;
  p3pc_pins_t alt_out;
  p3pc_pins_t alt_oe;

  assign latch_q = reg_q[0][9:0];
  assign dir_q = reg_q[1][9:0];
  assign fen_q = reg_q[2][9:0];
  assign alt_q = reg_q[3][9:0];
  assign pin2_fn = p3pc_pin2_fn_e'({ext_q[`P3PC_EXT_PIN2_BIT], alt_q[2]});

  always_comb begin
    alt_out = '0;
    alt_oe = '0;
    alt_out[0] = alt_q[0] ? serial4_data_out : uart0_transmit;
    alt_oe[0] = 1'b1;
    unique case (pin2_fn)
      p3pc_pin2_sclk: begin
        alt_out[2] = serial4_clock_out;
        alt_oe[2] = serial4_clock_oe;
      end
      p3pc_pin2_cmp: begin
        alt_out[2] = timer0_compare_out0;
        alt_oe[2] = 1'b1;
      end
      p3pc_pin2_baud, p3pc_pin2_cap: begin
        alt_out[2] = 1'b0;
        alt_oe[2] = 1'b0;
      end
    endcase
    alt_out[3] = timer0_compare_out1;
    alt_out[4] = timer1_compare_out0;
    alt_out[5] = timer1_compare_out1;
    alt_oe[5:3] = alt_q[5:3];
    alt_out[8] = alt_q[8] ? i2c0_data_line_out : uart2_transmit;
    alt_oe[8] = alt_q[8] ? i2c0_data_line_oe : 1'b1;
    alt_out[9] = i2c0_clock_line_out;
    alt_oe[9] = alt_q[9] & i2c0_clock_line_oe;
  end

  // ****************************************
  // pin drivers
  // ****************************************
  p3pc_pins_t next_out;
  p3pc_pins_t next_oe;

  for (genvar p = 0; p < 10; p++) begin : g_pin
    p3pc_pin_cell u_cell (
      .fen(fen_q[p]),
      .dir(dir_q[p]),
      .latch(latch_q[p]),
      .alt_out(alt_out[p]),
      .alt_oe(alt_oe[p]),
      .next_out(next_out[p]),
      .next_oe(next_oe[p])
    );
  end

  // registered pins cost one cycle of latency on peripheral outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= 10'h000;
      pin_oe <= 10'h000;
    end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end

  // ****************************************
  // peripheral inputs
  // ****************************************
  // unselected inputs rest at the line's idle level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uart0_receive <= 1'b1;
      external_irq7_in <= 1'b0;
      serial4_data_in <= 1'b0;
    end else begin
      // both share the pin; software keeps one of them quiet
      uart0_receive <= (fen_q[1] & ~alt_q[1]) ? pin_in[1] : 1'b1;
      external_irq7_in <= (fen_q[1] & ~alt_q[1]) ? pin_in[1] : 1'b0;
      serial4_data_in <= (fen_q[1] & alt_q[1]) ? pin_in[1] : 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uart0_baud_clock_in <= 1'b0;
      serial4_clock_in <= 1'b0;
      timer0_capture_in0 <= 1'b0;
    end else begin
      uart0_baud_clock_in <= (fen_q[2] && pin2_fn == p3pc_pin2_baud) && pin_in[2];
      serial4_clock_in <= (fen_q[2] && pin2_fn == p3pc_pin2_sclk) && pin_in[2];
      timer0_capture_in0 <= (fen_q[2] && pin2_fn == p3pc_pin2_cap) && pin_in[2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer0_capture_in1 <= 1'b0;
      timer1_capture_in0 <= 1'b0;
      timer1_capture_in1 <= 1'b0;
    end else begin
      timer0_capture_in1 <= fen_q[3] & ~alt_q[3] & pin_in[3];
      timer1_capture_in0 <= fen_q[4] & ~alt_q[4] & pin_in[4];
      timer1_capture_in1 <= fen_q[5] & ~alt_q[5] & pin_in[5];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uart2_receive <= 1'b1;
      i2c0_clock_line_in <= 1'b1;
      i2c0_data_line_in <= 1'b1;
    end else begin
      uart2_receive <= (fen_q[9] & ~alt_q[9]) ? pin_in[9] : 1'b1;
      i2c0_clock_line_in <= (fen_q[9] & alt_q[9]) ? pin_in[9] : 1'b1;
      i2c0_data_line_in <= (fen_q[8] & alt_q[8]) ? pin_in[8] : 1'b1;
    end
  end

endmodule : p3pc_top
`default_nettype wire

//--- dv/p3pc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module p3pc_pin_model (
  input wire logic [9:0] pin_out,
  input wire logic [9:0] pin_oe,
  input wire logic [9:0] ext_lvl,
  output logic [9:0] pin_in
);
  // a released pin shows the board level, which the bench keeps changing
  assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule : p3pc_pin_model
`default_nettype wire

//--- dv/p3pc_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "p3pc_params.svh"
module p3pc_top_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [9:0] pin_in,
  input wire logic [9:0] pin_oe,
  input wire logic uart0_receive,
  input wire logic external_irq7_in,
  input wire logic serial4_data_in,
  input wire logic uart0_baud_clock_in,
  input wire logic serial4_clock_in,
  input wire logic timer0_capture_in0,
  input wire logic timer1_capture_in0
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic rd_take = hsel && hready && htrans[1] && !hwrite;
  // ****************
  // bus side
  // ****************
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  rd_upper_a: assert property (rd_take |=> hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  dir_fixed_a: assert property (rd_take && haddr == (`P3PC_DIR_IDX << 2)
    |=> (hrdata[15:0] | 16'h033f) == 16'hffff) else $error("missing direction bit not one");
  // ****************
  // pin side
  // ****************
  no_pin_a: assert property (pin_oe[7:6] == 2'b00)
    else $error("missing pin driven");
  rx_follow_a: assert property (!uart0_receive |-> !$past(pin_in[1]))
    else $error("receive low without pin low");
  pin1_excl_a: assert property (!(external_irq7_in && serial4_data_in))
    else $error("pin 1 feeds two functions");
  pin2_one_a: assert property ($onehot0({uart0_baud_clock_in, serial4_clock_in,
    timer0_capture_in0})) else $error("pin 2 feeds two inputs");
  baud_follow_a: assert property (uart0_baud_clock_in |-> $past(pin_in[2]))
    else $error("baud input high without pin");
  cap_follow_a: assert property (timer1_capture_in0 |-> $past(pin_in[4]))
    else $error("capture high without pin");
endmodule : p3pc_top_monitor
bind p3pc_top p3pc_top_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .pin_in, .pin_oe, .uart0_receive, .external_irq7_in,
  .serial4_data_in, .uart0_baud_clock_in, .serial4_clock_in, .timer0_capture_in0,
  .timer1_capture_in0);
`default_nettype wire

//--- dv/p3pc_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "p3pc_params.svh"
module p3pc_top_tb_top import p3pc_pkg::*;;
  localparam logic [31:0] a_lat = `P3PC_LATCH_IDX << 2;
  localparam logic [31:0] a_dir = `P3PC_DIR_IDX << 2;
  localparam logic [31:0] a_fen = `P3PC_FEN_IDX << 2;
  localparam logic [31:0] a_alt = `P3PC_ALT_IDX << 2;
  localparam logic [31:0] a_ext = `P3PC_EXT_IDX << 2;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [9:0] ext_lvl = 0, pin_in, pin_out, pin_oe;
  logic [12:0] src = 0;
  logic [11:0] per;
  logic rd_dph = 0, port_evt = 0;
  logic [31:0] rd_q[$], port_q[$];
  int n_fail = 0, comparisons = 0, seed = 32'h39a1;
  assign hready = hreadyout;
  p3pc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .pin_in, .pin_out, .pin_oe, .uart0_transmit(src[12]),
    .serial4_data_out(src[11]), .serial4_clock_out(src[10]), .serial4_clock_oe(src[9]),
    .timer0_compare_out0(src[8]), .timer0_compare_out1(src[7]),
    .timer1_compare_out0(src[6]), .timer1_compare_out1(src[5]), .uart2_transmit(src[4]),
    .i2c0_data_line_out(src[3]), .i2c0_data_line_oe(src[2]), .i2c0_clock_line_out(src[1]),
    .i2c0_clock_line_oe(src[0]), .uart0_receive(per[11]), .external_irq7_in(per[10]),
    .serial4_data_in(per[9]), .uart0_baud_clock_in(per[8]), .serial4_clock_in(per[7]),
    .timer0_capture_in0(per[6]), .timer0_capture_in1(per[5]), .timer1_capture_in0(per[4]),
    .timer1_capture_in1(per[3]), .uart2_receive(per[2]), .i2c0_data_line_in(per[1]),
    .i2c0_clock_line_in(per[0]));
  p3pc_pin_model pins (.pin_out, .pin_oe, .ext_lvl, .pin_in);
  initial forever #4 hclk = ~hclk;
  // ****************
  // bus and compare tasks
  // ****************
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
    input logic [31:0] e);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= p3pc_htrans_nonseq;
    do @(posedge hclk); while (hready !== 1'b1);
    if (!w) rd_q.push_back(e);
    hsel <= 1'b0;
    htrans <= p3pc_htrans_idle;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : xfer
  task automatic tally(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : tally
  task automatic chk_rd(input logic [31:0] got);
    tally(got, rd_q.size() > 0 ? rd_q.pop_front() : 32'hx);
  endtask : chk_rd
  task automatic chk_port(input logic [31:0] got);
    tally(got, port_q.size() > 0 ? port_q.pop_front() : 32'hx);
  endtask : chk_port
  // pins and peripheral inputs settle within two edges; three leaves margin
  task automatic port_chk(input logic [31:0] e);
    repeat (3) @(posedge hclk);
    port_q.push_back(e);
    port_evt <= 1'b1;
    @(posedge hclk);
    port_evt <= 1'b0;
  endtask : port_chk
  // {peripheral inputs, pin enables, driven levels} for alternate mode k
  function automatic logic [31:0] port_exp(input logic [1:0] k, input logic [12:0] s,
    input logic [9:0] ext);
    logic a;
    logic [9:0] oe, o, p;
    a = k[0];
    oe = {2'b00, 2'b00, {3{a}}, k == 2'd3 || (k == 2'd1 && s[9]), 2'b01};
    oe[8] = a ? s[2] : 1'b1;
    oe[9] = a & s[0];
    o = {s[1], a ? s[3] : s[4], 2'b00, s[5], s[6], s[7], k == 2'd3 ? s[8] : s[10], 1'b0,
      a ? s[11] : s[12]} & oe;
    p = o | (ext & ~oe);
    return {a | p[1], !a & p[1], a & p[1], k == 2'd0 && p[2], k == 2'd1 && p[2],
      k == 2'd2 && p[2], !a & p[3], !a & p[4], !a & p[5], a | p[9], !a | p[8], !a | p[9],
      oe, o};
  endfunction : port_exp
  always @(posedge hclk) begin
    if (rd_dph && hready) chk_rd(hrdata);
    if (port_evt) chk_port({per, pin_oe, pin_out & pin_oe});
    if (hready) rd_dph <= hsel && htrans[1] && !hwrite;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    repeat (5000) @(posedge hclk);
    $display("[ERR] %0t timeout", $time);
    n_fail++;
    stop_test();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    logic [15:0] d;
    logic [7:0] r;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ext_lvl <= 10'($random(seed));
    port_chk({12'h807, 20'h0});
    xfer(a_lat, 0, 0, 32'(ext_lvl & 10'h33f));
    xfer(a_lat + 4, 0, 0, 32'(ext_lvl[9:8]));
    xfer(a_dir, 0, 0, 32'hffff);
    xfer(a_dir + 4, 0, 0, 32'hff);
    xfer(a_fen, 0, 0, 0);
    xfer(a_alt, 0, 0, 0);
    xfer(a_ext, 0, 0, 0);
    xfer(32'hffffd000, 1, 32'hffff, 0);
    xfer(32'hffffd000, 0, 0, 0);
    xfer(a_alt, 1, 32'hffffffff, 0);
    xfer(a_alt, 0, 0, 32'h33f);
    xfer(a_ext, 1, 32'hffffffff, 0);
    xfer(a_ext, 0, 0, 32'h4);
    $display("test reset_values done");
    d = 16'($random(seed));
    r = 8'($random(seed));
    xfer(a_dir, 1, 0, 0);
    xfer(a_lat, 1, {16'h0, d}, 0);
    xfer(a_dir, 0, 0, 32'hfcc0);
    xfer(a_lat, 0, 0, 32'(d & 16'h033f));
    port_chk({12'h807, 10'h33f, d[9:0] & 10'h33f});
    xfer(a_lat + 4, 1, 32'(r), 0);
    xfer(a_lat + 4, 0, 0, 32'(r & 8'h03));
    xfer(a_dir + 4, 1, 32'hff, 0);
    port_chk({12'h807, 10'h03f, 4'h0, d[5:0]});
    xfer(a_lat, 0, 0, {22'h0, ext_lvl[9:8], 2'b00, d[5:0]});
    // narrow writes touch only their own lanes
    hsize <= 3'h0;
    xfer(a_dir + 1, 1, 32'h000000ff, 0);
    hsize <= 3'h1;
    xfer(a_dir + 2, 1, 32'h0000ffff, 0);
    hsize <= 3'h2;
    xfer(a_dir, 0, 0, 32'hfcc0);
    port_chk({12'h807, 10'h33f, r[1:0], 2'b00, d[5:0]});
    $display("test port_mode done");
    xfer(a_fen, 1, 32'hffff, 0);
    for (int k = 0; k < 4; k++) begin
      xfer(a_ext, 1, {29'h0, k[1], 2'b00}, 0);
      xfer(a_alt, 1, k[0] ? 32'hffff : 32'h0, 0);
      xfer(a_alt, 0, 0, k[0] ? 32'h33f : 32'h0);
      repeat (4) begin
        src <= 13'($random(seed));
        ext_lvl <= 10'($random(seed));
        @(posedge hclk);
        port_chk(port_exp(2'(k), src, ext_lvl));
      end
    end
    $display("test alternate done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    src <= 13'h0;
    @(posedge hclk);
    xfer(a_fen, 0, 0, 0);
    xfer(a_ext, 0, 0, 0);
    xfer(a_dir, 0, 0, 32'hffff);
    xfer(a_alt, 0, 0, 0);
    port_chk({12'h807, 20'h0});
    $display("test second_reset done");
    repeat (3) @(posedge hclk);
    stop_test();
  end
endmodule : p3pc_top_tb_top
`default_nettype wire
